// file: core/mnp_pkg.sv
// Constants and types for the multiply, negate, idle and stack-discard executor
package mnp_pkg;
  localparam logic [15:0] OPC_MASK_FILE   = 16'hFE00;
  localparam logic [15:0] OPC_MUL_FILE    = 16'h0200;
  localparam logic [15:0] OPC_NEG_FILE    = 16'h6C00;
  localparam logic [15:0] OPC_MASK_LIT    = 16'hFF00;
  localparam logic [15:0] OPC_MUL_LIT     = 16'h0D00;
  localparam logic [15:0] OPC_POP         = 16'h0006;
  localparam logic [15:0] OPC_IDLE        = 16'h0000;
  localparam logic [3:0]  OPC_IDLE_NIB    = 4'hF;
  localparam int          ACCESS_BIT_POS  = 8;
  localparam logic [7:0]  INDEXED_MAX_F   = 8'h5F;
  localparam logic [7:0]  ACCESS_SPLIT    = 8'h60;
  localparam logic [3:0]  ACCESS_HI_BANK  = 4'hF;
  localparam logic [7:0]  PROD_RST        = 8'h00;
  localparam logic [4:0]  STATUS_RST      = 5'h00;
  localparam logic [4:0]  STACK_PTR_RST   = 5'h00;
  localparam int          ST_C  = 0;
  localparam int          ST_DC = 1;
  localparam int          ST_Z  = 2;
  localparam int          ST_OV = 3;
  localparam int          ST_N  = 4;
  typedef enum logic [2:0] {
    OP_IDLE, OP_MUL_FILE, OP_MUL_LIT, OP_NEG, OP_POP, OP_OTHER
  } op_type;
endpackage

// file: core/multiply_negate_pop_exec.sv
// Executor for multiply, negate-file, idle and stack-discard instructions
//
// Overview of operation
// - Multiply-by-file stores 16-bit unsigned acc times file into product pair.
// - Multiply-by-file modifies neither accumulator nor source file register.
// - Multiplies never touch status flags, even on a zero product.
// - Access bit 0 selects access bank; 1 uses bank select register.
// - Access 0, extended set on, file at most 95: indexed literal offset.
// - Negate-file writes inverse plus one back to same location.
// - Negate-file updates negative, overflow, carry, digit carry, zero flags.
// - Negate-file decoded by opcode 0110 110a with file address low byte.
// - Stack discard removes top entry and writes it nowhere.
// - After discard, top shows the entry pushed before the discarded one.
// - Multiply-by-literal stores acc times eight-bit literal into product pair.
`timescale 1ns/1ps
`default_nettype none
module multiply_negate_pop_exec
  import mnp_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int PC_W        = 21
) (
  input  wire logic            clk_i,
  input  wire logic            rstn_i,
  input  wire logic            instr_valid_i,
  input  wire logic [15:0]     instr_i,
  input  wire logic [7:0]      acc_i,
  input  wire logic [3:0]      bank_select_register_i,
  input  wire logic [7:0]      fsr2_i,
  input  wire logic            ext_set_en_i,
  input  wire logic [7:0]      file_rdata_i,
  input  wire logic            push_i,
  input  wire logic [PC_W-1:0] push_data_i,
  output logic [11:0]          file_addr_o,
  output logic [11:0]          file_waddr_o,
  output logic [7:0]           file_wdata_o,
  output logic                 file_we_o,
  output logic [7:0]           product_high_o,
  output logic [7:0]           product_low_o,
  output logic [4:0]           status_o,
  output logic [PC_W-1:0]      return_stack_top_o,
  output logic [4:0]           stack_ptr_o,
  output logic                 stack_underflow_o
);

  // ********************************************
  // Decode
  // ********************************************
  op_type     op;
  logic       acc_bit;
  logic [7:0] f_lo;
  logic       indexed;

  assign acc_bit = instr_i[ACCESS_BIT_POS];
  assign f_lo    = instr_i[7:0];

  // Idle patterns take priority over every other decode
  always_comb begin
    op = OP_OTHER;
    if (!instr_valid_i || instr_i == OPC_IDLE || instr_i[15:12] == OPC_IDLE_NIB) begin
      op = OP_IDLE;
    end else if ((instr_i & OPC_MASK_FILE) == OPC_MUL_FILE) begin
      op = OP_MUL_FILE;
    end else if ((instr_i & OPC_MASK_FILE) == OPC_NEG_FILE) begin
      op = OP_NEG;
    end else if ((instr_i & OPC_MASK_LIT) == OPC_MUL_LIT) begin
      op = OP_MUL_LIT;
    end else if (instr_i == OPC_POP) begin
      op = OP_POP;
    end
  end

  // ********************************************
  // File address formation
  // ********************************************
  assign indexed = !acc_bit && ext_set_en_i && (f_lo <= INDEXED_MAX_F);
  logic [7:0] idx_sum;
  // Indexed addresses stay in the lowest bank
  assign idx_sum = 8'(fsr2_i + f_lo);

  always_comb begin
    if (indexed) begin
      file_addr_o = {4'h0, idx_sum};
    end else if (acc_bit) begin
      file_addr_o = {bank_select_register_i, f_lo};
    end else if (f_lo < ACCESS_SPLIT) begin
      file_addr_o = {4'h0, f_lo};
    end else begin
      file_addr_o = {ACCESS_HI_BANK, f_lo};
    end
  end

  // ********************************************
  // Negate and flags
  // ********************************************
  logic [8:0] neg_sum;
  logic [4:0] neg_dc;
  logic [7:0] neg_res;
  assign neg_sum = {1'b0, ~file_rdata_i} + 9'h001;
  assign neg_dc  = {1'b0, ~file_rdata_i[3:0]} + 5'h01;
  assign neg_res = neg_sum[7:0];
  logic       neg_c;
  logic       neg_ov;
  assign neg_c   = neg_sum[8];
  // Overflow only when 0x80 negates to itself
  assign neg_ov  = file_rdata_i[7] & neg_res[7];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_we_o <= 1'b0;
    end else begin
      file_we_o <= (op == OP_NEG);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      file_waddr_o <= 12'h000;
      file_wdata_o <= 8'h00;
    end else if (op == OP_NEG) begin
      file_waddr_o <= file_addr_o;
      file_wdata_o <= neg_res;
    end
  end

  logic [4:0] status_r;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      status_r <= STATUS_RST;
    end else if (op == OP_NEG) begin
      status_r[ST_C]  <= neg_c;
      status_r[ST_DC] <= neg_dc[4];
      status_r[ST_Z]  <= (neg_res == 8'h00);
      status_r[ST_OV] <= neg_ov;
      status_r[ST_N]  <= neg_res[7];
    end
  end
  // Multiplies, idle and discard never reach the flags
  assign status_o = status_r;

  // ********************************************
  // Product pair
  // ********************************************
  logic [7:0]  prod_h_r;
  logic [7:0]  prod_l_r;
  logic [15:0] prod;
  logic [7:0]  mul_src;
  logic        mul_go;
  assign mul_go  = (op == OP_MUL_FILE) || (op == OP_MUL_LIT);
  assign mul_src = (op == OP_MUL_LIT) ? f_lo : file_rdata_i;
  assign prod    = 16'(acc_i) * 16'(mul_src);

  // Upper byte of the product lands in product_high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prod_h_r <= PROD_RST;
      prod_l_r <= PROD_RST;
    end else if (mul_go) begin
      prod_h_r <= prod[15:8];
      prod_l_r <= prod[7:0];
    end
  end
  assign product_high_o = prod_h_r;
  assign product_low_o  = prod_l_r;

  // ********************************************
  // Return stack
  // ********************************************
  logic [PC_W-1:0] stack_mem [STACK_DEPTH+1];
  logic [4:0]      sp_r;
  logic            unf_r;
  logic            pop_go;
  logic            push_go;

  // Push is dropped in a discard cycle and when the stack is full
  assign pop_go  = (op == OP_POP) && (sp_r != STACK_PTR_RST);
  assign push_go = (op != OP_POP) && push_i && (sp_r < 5'(STACK_DEPTH));

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_r <= STACK_PTR_RST;
    end else if (pop_go) begin
      sp_r <= sp_r - 5'h01;
    end else if (push_go) begin
      sp_r <= sp_r + 5'h01;
    end
  end

  // Discard on an empty stack only raises the sticky underflow flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unf_r <= 1'b0;
    end else if (op == OP_POP && sp_r == STACK_PTR_RST) begin
      unf_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push_go) begin
      stack_mem[sp_r + 5'h01] <= push_data_i;
    end
  end

  assign return_stack_top_o = (sp_r == STACK_PTR_RST) ? '0 : stack_mem[sp_r];
  assign stack_ptr_o        = sp_r;
  assign stack_underflow_o  = unf_r;

  // ********************************************
  // Assertions
  // ********************************************
  a_mul_product: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_MUL_FILE |=> {prod_h_r, prod_l_r} == $past(acc_i) * $past(file_rdata_i))
    else $error("product pair wrong after file multiply");
  a_mul_nowrite: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_MUL_FILE |=> !file_we_o)
    else $error("file written during multiply");
  a_mul_flags: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (op == OP_MUL_FILE || op == OP_MUL_LIT) |=> $stable(status_r))
    else $error("status changed by multiply");
  a_bank_sel: assert property (@(posedge clk_i) disable iff (!rstn_i)
    acc_bit |-> file_addr_o == {bank_select_register_i, f_lo})
    else $error("bank select not used");
  a_indexed_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!acc_bit && ext_set_en_i && f_lo <= INDEXED_MAX_F) |-> file_addr_o == {4'h0, 8'(fsr2_i + f_lo)})
    else $error("indexed offset not applied");
  a_neg_result: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG |=> file_we_o && file_wdata_o == 8'(-$past(file_rdata_i)))
    else $error("negate result wrong");
  a_neg_zero: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG |=> status_r[ST_Z] == (file_wdata_o == 8'h00)
      && status_r[ST_N] == file_wdata_o[7])
    else $error("negate flags wrong");
  a_neg_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (instr_valid_i && instr_i[15:9] == 7'h36) |-> op == OP_NEG)
    else $error("negate not decoded");
  a_pop_ptr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (op == OP_POP && sp_r != 5'h00) |=> sp_r == $past(sp_r) - 5'h01)
    else $error("discard did not drop top");
  a_idle_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (op == OP_IDLE && !push_i) |=> !file_we_o && $stable(status_r) && $stable(sp_r)
      && $stable(prod_l_r) && $stable(prod_h_r))
    else $error("idle changed state");
  a_lit_product: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_MUL_LIT |=> {prod_h_r, prod_l_r} == $past(acc_i) * $past(f_lo))
    else $error("literal product wrong");
  a_lit_nowrite: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_MUL_LIT |=> !file_we_o)
    else $error("file written during literal multiply");
  a_mul_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (instr_valid_i && instr_i[15:9] == 7'h01) |-> op == OP_MUL_FILE)
    else $error("file multiply not decoded");
  a_lit_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (instr_valid_i && instr_i[15:8] == 8'h0D) |-> op == OP_MUL_LIT)
    else $error("literal multiply not decoded");
  a_idle_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (instr_i == OPC_IDLE || instr_i[15:12] == OPC_IDLE_NIB) |-> op == OP_IDLE)
    else $error("idle word not decoded");

  a_access_low: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!acc_bit && !ext_set_en_i && f_lo < ACCESS_SPLIT) |-> file_addr_o == {4'h0, f_lo})
    else $error("low access bank address wrong");
  a_access_high: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!acc_bit && f_lo >= ACCESS_SPLIT) |-> file_addr_o == {ACCESS_HI_BANK, f_lo})
    else $error("high access bank address wrong");

  a_neg_carry: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG |=> status_r[ST_C] == ($past(file_rdata_i) == 8'h00)
      && status_r[ST_DC] == ($past(file_rdata_i[3:0]) == 4'h0))
    else $error("negate carry flags wrong");
  a_neg_ovf: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG |=> status_r[ST_OV] == ($past(file_rdata_i) == 8'h80))
    else $error("negate overflow flag wrong");
  a_neg_addr: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG |=> file_waddr_o == $past(file_addr_o))
    else $error("negate written to wrong location");
  a_we_pulse: assert property (@(posedge clk_i) disable iff (!rstn_i)
    file_we_o |-> $past(op == OP_NEG))
    else $error("file write without negate");

  a_pop_top: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (op == OP_POP && sp_r > 5'h01) |=> return_stack_top_o == $past(stack_mem[sp_r - 5'h01]))
    else $error("discard exposed wrong entry");
  a_pop_empty: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (op == OP_POP && sp_r == 5'h00) |=> stack_underflow_o && sp_r == 5'h00)
    else $error("empty discard handled wrong");
  a_pop_quiet: assert property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_POP |=> !file_we_o && $stable(status_r) && $stable(prod_h_r))
    else $error("discarded entry written somewhere");
  a_pop_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (instr_valid_i && instr_i == OPC_POP) |-> op == OP_POP)
    else $error("discard not decoded");

  // ********************************************
  // Cover properties
  // ********************************************

  c_mul_file: cover property (@(posedge clk_i) disable iff (!rstn_i) op == OP_MUL_FILE);
  c_neg_zero: cover property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG && file_rdata_i == 8'h00);
  c_pop_deep: cover property (@(posedge clk_i) disable iff (!rstn_i) op == OP_POP && sp_r > 5'd1);
  c_indexed: cover property (@(posedge clk_i) disable iff (!rstn_i) op == OP_NEG && indexed);
  c_neg_ovf: cover property (@(posedge clk_i) disable iff (!rstn_i)
    op == OP_NEG && file_rdata_i == 8'h80);

endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the multiply, negate, idle and stack-discard executor
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mnp_pkg::*;
  // ****************
  // Signals
  // ****************
  logic        clk_i, rstn_i, instr_valid_i, ext_set_en_i, push_i, file_we_o, stack_underflow_o;
  logic [15:0] instr_i;
  logic [7:0]  acc_i, fsr2_i, file_rdata_i, file_wdata_o, product_high_o, product_low_o;
  logic [3:0]  bank_select_register_i;
  logic [20:0] push_data_i, return_stack_top_o;
  logic [11:0] file_addr_o, file_waddr_o;
  logic [4:0]  status_o, stack_ptr_o, st;
  logic [3:0]  bank_v;
  logic [7:0]  fsr_v, a, r, res;
  logic        ext_v;
  logic [15:0] ins, prod;
  logic [31:0] e, g;
  logic [20:0] stk[$];
  int          kq[$];
  logic [31:0] vq[$];
  int          seed, error_cnt, checks_done, k, i;

  multiply_negate_pop_exec #(.STACK_DEPTH(31), .PC_W(21)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .acc_i(acc_i), .bank_select_register_i(bank_select_register_i), .fsr2_i(fsr2_i),
    .ext_set_en_i(ext_set_en_i), .file_rdata_i(file_rdata_i), .push_i(push_i),
    .push_data_i(push_data_i), .file_addr_o(file_addr_o), .file_waddr_o(file_waddr_o),
    .file_wdata_o(file_wdata_o), .file_we_o(file_we_o), .product_high_o(product_high_o),
    .product_low_o(product_low_o), .status_o(status_o), .return_stack_top_o(return_stack_top_o),
    .stack_ptr_o(stack_ptr_o), .stack_underflow_o(stack_underflow_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ****************
  // Tasks
  // ****************
  task automatic note(input int kind, input logic [31:0] v);
    kq.push_back(kind);
    vq.push_back(v);
  endtask
  task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic [7:0] ac);
    @(negedge clk_i);
    instr_valid_i = 1'b1;
    instr_i = w;
    file_rdata_i = rd;
    acc_i = ac;
    push_i = 1'b0;
    bank_select_register_i = bank_v;
    fsr2_i = fsr_v;
    ext_set_en_i = ext_v;
    @(posedge clk_i);
  endtask
  task automatic push(input logic [20:0] d);
    @(negedge clk_i);
    instr_valid_i = 1'b0;
    push_i = 1'b1;
    push_data_i = d;
    @(posedge clk_i);
    stk.push_back(d);
  endtask
  function automatic logic [11:0] ea(input logic [15:0] w);
    if (w[8]) return {bank_v, w[7:0]};
    if (ext_v && w[7:0] <= INDEXED_MAX_F) return {4'h0, 8'(fsr_v + w[7:0])};
    return (w[7:0] < ACCESS_SPLIT) ? {4'h0, w[7:0]} : {ACCESS_HI_BANK, w[7:0]};
  endfunction
  function automatic logic [31:0] stk_note(input logic u);
    return {5'h00, u, 5'(stk.size()), stk.size() ? stk[$] : 21'h00_0000};
  endfunction
  task automatic wrap_up();
    $display("Checks: %0d, errors: %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****************
  // Monitor
  // ****************
  always @(posedge clk_i) begin
    #1;
    while (kq.size() > 0) begin
      k = kq.pop_front();
      e = vq.pop_front();
      case (k)
        0: g = {16'h0000, product_high_o, product_low_o};
        1: g = {31'h0000_0000, file_we_o};
        2: g = {27'h000_0000, status_o};
        3: g = {5'h00, stack_underflow_o, stack_ptr_o, return_stack_top_o};
        4: g = {20'h0_0000, file_addr_o};
        default: g = {12'h000, file_waddr_o, file_wdata_o};
      endcase
      checks_done++;
      if (g !== e) begin
        error_cnt++;
        $display("MISMATCH t=%0t kind=%0d exp=%h got=%h", $time, k, e, g);
      end
    end
  end
  initial begin
    #2_000_000;
    error_cnt++;
    wrap_up();
  end
  // ****************
  // Main sequence
  // ****************
  initial begin
    seed = 74;
    {rstn_i, instr_valid_i, ext_set_en_i, push_i, instr_i, acc_i, fsr2_i} = '0;
    {file_rdata_i, bank_select_register_i, push_data_i, bank_v, fsr_v, ext_v} = '0;
    st = STATUS_RST;
    prod = 16'h0000;
    repeat (6) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    note(0, 32'h0000_0000);
    note(2, 32'h0000_0000);
    note(3, 32'h0000_0000);
    for (i = 0; i < 120; i++) begin
      bank_v = 4'($random(seed));
      fsr_v = 8'($random(seed));
      ext_v = 1'($random(seed));
      a = (i == 1) ? 8'hFF : 8'($random(seed));
      r = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      ins = i[0] ? {OPC_MUL_LIT[15:8], r} : {7'h01, 1'($random(seed)), 8'($random(seed))};
      if (i >= 40) ins = {7'h36, 1'($random(seed)), (i < 43) ? 8'h5F + 8'(i - 40) : r};
      if (i >= 80) ins = (i == 80) ? OPC_IDLE : {OPC_IDLE_NIB, 12'($random(seed))};
      if (i >= 40 && i < 44) r = (i == 40) ? 8'h00 : (i == 41) ? 8'h80 : 8'h3A;
      exec(ins, r, a);
      if (i < 40) prod = 16'(a) * 16'(r);
      res = ~r + 8'h01;
      if (i >= 40 && i < 80) st = {res[7], r == 8'h80, res == 8'h00, r[3:0] == 4'h0, r == 8'h00};
      note(0, {16'h0000, prod});
      note(2, {27'h000_0000, st});
      note(1, {31'h0000_0000, i >= 40 && i < 80});
      if (!i[0] || (i >= 40 && i < 80)) note(4, {20'h0_0000, ea(ins)});
      if (i >= 40 && i < 80) note(5, {12'h000, ea(ins), res});
    end
    for (i = 0; i < 5; i++) begin
      push(21'($random(seed)));
      note(3, stk_note(1'b0));
    end
    for (i = 0; i < 7; i++) begin
      exec(OPC_POP, 8'($random(seed)), 8'($random(seed)));
      if (stk.size() > 0) void'(stk.pop_back());
      note(3, stk_note(i >= 5));
    end
    @(negedge clk_i) instr_valid_i = 1'b0;
    @(negedge clk_i) rstn_i = 1'b0;
    repeat (2) @(posedge clk_i);
    @(negedge clk_i) rstn_i = 1'b1;
    note(0, 32'h0000_0000);
    note(1, 32'h0000_0000);
    note(2, 32'h0000_0000);
    note(3, 32'h0000_0000);
    note(5, 32'h0000_0000);
    repeat (3) @(posedge clk_i);
    wrap_up();
  end
endmodule
`default_nettype wire
